// ### hdl/icp_core.sv
// phase generator, fetch/execute pipeline and accumulator datapath
`timescale 1ns/10ps
module icp_core
	import icp_pkg::*;
#(
	parameter int PC_W = ICP_PC_W,
	parameter int IW = ICP_IW
)
(
	input wire logic CLK_I, // fast internal rc clock
	input wire logic NRST_I, // async reset, active low
	input wire logic SLOW_RC_CLK_I, // slow internal rc clock
	input wire logic FAST_XT_CLK_I, // fast crystal clock
	input wire logic SLOW_XT_CLK_I, // slow crystal clock
	input wire logic [1:0] CLK_SEL_I, // system clock source
	input wire logic [IW-1:0] INSTR_I, // program memory word at FETCH_ADDR_O
	input wire logic EXTENDED_I, // executing instruction is extended
	input wire logic BRANCH_I, // executing instruction changes pc
	input wire logic [PC_W-1:0] TARGET_I, // branch target
	input wire logic SKIP_I, // skip instruction executing
	input wire logic PCL_WR_I, // executing instruction writes pc low byte
	input wire logic [3:0] ALU_OP_I, // alu operation of current instruction
	input wire logic [ICP_DW-1:0] OPERAND_I, // memory operand
	input wire logic ACC_WR_I, // result goes to the accumulator
	output logic [3:0] PHASE_O, // one-hot phase clocks
	output logic [PC_W-1:0] FETCH_ADDR_O, // program memory address
	output logic FETCH_O, // fetch strobe, phase one
	output logic [IW-1:0] IR_O, // instruction in execution
	output logic EXEC_VALID_O, // ir holds a real instruction
	output logic RETIRE_O, // instruction other than a branch or pc low write completes
	output logic [ICP_DW-1:0] ACC_O, // accumulator
	output logic [ICP_DW-1:0] RESULT_O, // alu result register
	output logic CARRY_O, // carry flag
	output logic SYS_TICK_O // system clock tick in use
);
	logic [1:0] rst_sync_q;
	logic rst_n;
	logic [2:0] srcsync_q [3];
	logic [2:0] srcsync_d [3];
	logic [2:0] sel_edge;
	logic tick;
	icp_phase_t phase_q, phase_d;
	icp_ex_t ex_q, ex_d;
	logic [PC_W-1:0] pc_q, pc_d;
	logic [IW-1:0] ir_q, ir_d;
	logic valid_q, valid_d;
	logic [ICP_DW-1:0] acc_q, acc_d, res_q, res_d, alu_res;
	logic carry_q, carry_d, alu_carry, alu_zero;
	logic [3:0] phase_oh;

	////////////////////////////////////////////////////////////////////////
	// reset release through two flip-flops
	always_ff @(posedge CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			rst_sync_q <= 2'h0;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n = rst_sync_q[1];

	////////////////////////////////////////////////////////////////////////
	// slower sources are pins: three stages, edge when stage two is high and stage three is still low
	always_comb
	begin
		srcsync_d[0] = {srcsync_q[0][1:0], SLOW_RC_CLK_I};
		srcsync_d[1] = {srcsync_q[1][1:0], FAST_XT_CLK_I};
		srcsync_d[2] = {srcsync_q[2][1:0], SLOW_XT_CLK_I};
		for (int i = 0; i < 3; i++)
			sel_edge[i] = srcsync_q[i][1] & ~srcsync_q[i][2];
	end

	always_ff @(posedge CLK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			srcsync_q[0] <= 3'h0;
			srcsync_q[1] <= 3'h0;
			srcsync_q[2] <= 3'h0;
		end
		else
		begin
			srcsync_q[0] <= srcsync_d[0];
			srcsync_q[1] <= srcsync_d[1];
			srcsync_q[2] <= srcsync_d[2];
		end
	end

	// system clock source select
	// no tick while held in reset, so the fetch strobe never shows a fetch that reset blocks
	always_comb
	begin
		case (CLK_SEL_I)
			ICP_SRC_FAST_RC: tick = rst_n;
			ICP_SRC_SLOW_RC: tick = sel_edge[0];
			ICP_SRC_FAST_XT: tick = sel_edge[1];
			ICP_SRC_SLOW_XT: tick = sel_edge[2];
			default: tick = rst_n;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// alu; the only path from operands to results
	icp_alu #(
		.DW(ICP_DW)
	) u_alu (
		.op_i(ALU_OP_I),
		.acc_i(acc_q),
		.opd_i(OPERAND_I),
		.carry_i(carry_q),
		.res_o(alu_res),
		.carry_o(alu_carry),
		.zero_o(alu_zero)
	);

	////////////////////////////////////////////////////////////////////////
	// phase sequencer and pipeline next state
	always_comb
	begin
		phase_d = phase_q;
		ex_d = ex_q;
		pc_d = pc_q;
		ir_d = ir_q;
		valid_d = valid_q;
		acc_d = acc_q;
		res_d = res_q;
		carry_d = carry_q;
		if (tick)
		begin
			case (phase_q)
				ICP_PH1: phase_d = ICP_PH2;
				ICP_PH2: phase_d = ICP_PH3;
				ICP_PH3: phase_d = ICP_PH4;
				ICP_PH4: phase_d = ICP_PH1;
				default: phase_d = ICP_PH1;
			endcase
			// extended writes back once, in its second cycle
			if (phase_q == ICP_PH4 && valid_q && ex_q != ICP_EX_DUMMY
				&& !(ex_q == ICP_EX_NORMAL && EXTENDED_I))
			begin
				res_d = alu_res;
				carry_d = alu_carry;
				if (ACC_WR_I)
					acc_d = alu_res;
			end
			// fetch and pc increment at phase one
			if (phase_q == ICP_PH1)
			begin
				ir_d = INSTR_I;
				pc_d = pc_q + {{(PC_W-1){1'b0}}, 1'b1};
				valid_d = 1'b1;
				ex_d = ICP_EX_NORMAL;
				if (valid_q)
				begin
					case (ex_q)
						ICP_EX_NORMAL:
						begin
							if (EXTENDED_I)
							begin
								ex_d = ICP_EX_SECOND;
								ir_d = ir_q;
								pc_d = pc_q;
							end
							else if (BRANCH_I)
							begin
								pc_d = TARGET_I;
								ex_d = ICP_EX_DUMMY;
							end
							else if (PCL_WR_I)
							begin
								pc_d = {pc_q[PC_W-1:ICP_PAGE_LSB], alu_res};
								ex_d = ICP_EX_DUMMY;
							end
							else if (SKIP_I && alu_zero)
								ex_d = ICP_EX_DUMMY;
						end
						ICP_EX_SECOND:
						begin
							if (BRANCH_I)
							begin
								pc_d = TARGET_I;
								ex_d = ICP_EX_DUMMY;
							end
							else if (SKIP_I && alu_zero)
								ex_d = ICP_EX_DUMMY;
						end
						default: ex_d = ICP_EX_NORMAL;
					endcase
				end
			end
		end
	end

	always_ff @(posedge CLK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			phase_q <= ICP_PH1;
			ex_q <= ICP_EX_NORMAL;
			pc_q <= ICP_RESET_PC;
			ir_q <= '0;
			valid_q <= 1'b0;
			acc_q <= '0;
			res_q <= '0;
			carry_q <= 1'b0;
		end
		else
		begin
			phase_q <= phase_d;
			ex_q <= ex_d;
			pc_q <= pc_d;
			ir_q <= ir_d;
			valid_q <= valid_d;
			acc_q <= acc_d;
			res_q <= res_d;
			carry_q <= carry_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs; one-hot phases never overlap
	always_comb
	begin
		phase_oh = 4'h0;
		case (phase_q)
			ICP_PH1: phase_oh = 4'h1;
			ICP_PH2: phase_oh = 4'h2;
			ICP_PH3: phase_oh = 4'h4;
			ICP_PH4: phase_oh = 4'h8;
			default: phase_oh = 4'h0;
		endcase
	end

	assign PHASE_O = phase_oh;
	assign FETCH_ADDR_O = pc_q;
	assign FETCH_O = tick & (phase_q == ICP_PH1);
	assign IR_O = ir_q;
	assign EXEC_VALID_O = valid_q & (ex_q != ICP_EX_DUMMY);
	assign RETIRE_O = tick & (phase_q == ICP_PH4) & valid_q & (ex_q != ICP_EX_DUMMY)
		& ~(ex_q == ICP_EX_NORMAL & EXTENDED_I) & ~BRANCH_I & ~PCL_WR_I;
	assign ACC_O = acc_q;
	assign RESULT_O = res_q;
	assign CARRY_O = carry_q;
	assign SYS_TICK_O = tick;
endmodule : icp_core

// ### hdl/icp_pkg.sv
// constants and types for the instruction cycle pipeline
package icp_pkg;
	localparam int ICP_PC_W = 14;
	localparam int ICP_DW = 8;
	localparam int ICP_IW = 16;
	localparam logic [13:0] ICP_RESET_PC = 14'h0000;
	localparam int ICP_PAGE_LSB = 8;
	localparam logic [1:0] ICP_SRC_FAST_RC = 2'h0;
	localparam logic [1:0] ICP_SRC_SLOW_RC = 2'h1;
	localparam logic [1:0] ICP_SRC_FAST_XT = 2'h2;
	localparam logic [1:0] ICP_SRC_SLOW_XT = 2'h3;
	localparam logic [3:0] ICP_OP_ADD = 4'h0;
	localparam logic [3:0] ICP_OP_SUB = 4'h1;
	localparam logic [3:0] ICP_OP_AND = 4'h2;
	localparam logic [3:0] ICP_OP_OR = 4'h3;
	localparam logic [3:0] ICP_OP_XOR = 4'h4;
	localparam logic [3:0] ICP_OP_CPL = 4'h5;
	localparam logic [3:0] ICP_OP_RR = 4'h6;
	localparam logic [3:0] ICP_OP_RL = 4'h7;
	localparam logic [3:0] ICP_OP_INC = 4'h8;
	localparam logic [3:0] ICP_OP_DEC = 4'h9;
	localparam logic [3:0] ICP_OP_MOV = 4'ha;
	localparam logic [3:0] ICP_OP_LDA = 4'hb;
	typedef enum {ICP_PH1, ICP_PH2, ICP_PH3, ICP_PH4} icp_phase_t;
	typedef enum {ICP_EX_NORMAL, ICP_EX_SECOND, ICP_EX_DUMMY} icp_ex_t;
endpackage : icp_pkg

// ### hdl/icp_alu.sv
// eight bit alu used by the execute phases
`timescale 1ns/10ps
module icp_alu
	import icp_pkg::*;
#(
	parameter int DW = ICP_DW
)
(
	input wire logic [3:0] op_i, // operation select
	input wire logic [DW-1:0] acc_i, // accumulator operand
	input wire logic [DW-1:0] opd_i, // second operand
	input wire logic carry_i, // carry in
	output logic [DW-1:0] res_o, // result
	output logic carry_o, // carry out
	output logic zero_o // result is zero, for skip decisions
);
	logic [DW:0] sum;

	always_comb
	begin
		sum = '0;
		carry_o = carry_i;
		case (op_i)
			ICP_OP_ADD:
			begin
				sum = {1'b0, acc_i} + {1'b0, opd_i} + {{DW{1'b0}}, carry_i};
				carry_o = sum[DW];
			end
			ICP_OP_SUB:
			begin
				sum = {1'b0, acc_i} - {1'b0, opd_i};
				carry_o = ~sum[DW];
			end
			ICP_OP_AND: sum = {1'b0, acc_i & opd_i};
			ICP_OP_OR: sum = {1'b0, acc_i | opd_i};
			ICP_OP_XOR: sum = {1'b0, acc_i ^ opd_i};
			ICP_OP_CPL: sum = {1'b0, ~opd_i};
			ICP_OP_RR: sum = {1'b0, opd_i[0], opd_i[DW-1:1]};
			ICP_OP_RL: sum = {1'b0, opd_i[DW-2:0], opd_i[DW-1]};
			ICP_OP_INC: sum = {1'b0, opd_i} + {{DW{1'b0}}, 1'b1};
			ICP_OP_DEC: sum = {1'b0, opd_i} - {{DW{1'b0}}, 1'b1};
			ICP_OP_MOV: sum = {1'b0, acc_i};
			ICP_OP_LDA: sum = {1'b0, opd_i};
			default: sum = {1'b0, acc_i};
		endcase
		res_o = sum[DW-1:0];
		zero_o = (sum[DW-1:0] == '0);
	end
endmodule : icp_alu

// ### tb/icp_core_checker.sv
// port checker for the pipeline core
`timescale 1ns/10ps
module icp_core_checker
	import icp_pkg::*;
#(
	parameter int PC_W = ICP_PC_W,
	parameter int IW = ICP_IW
)
(
	input wire logic CLK_I, // clock
	input wire logic NRST_I, // reset
	input wire logic [IW-1:0] INSTR_I, // word
	input wire logic EXTENDED_I, // ext
	input wire logic BRANCH_I, // jump
	input wire logic [PC_W-1:0] TARGET_I, // target
	input wire logic SKIP_I, // skip
	input wire logic PCL_WR_I, // pc low
	input wire logic [3:0] PHASE_O, // phase
	input wire logic [PC_W-1:0] FETCH_ADDR_O, // pc
	input wire logic FETCH_O, // fetch
	input wire logic [IW-1:0] IR_O, // ir
	input wire logic EXEC_VALID_O, // valid
	input wire logic RETIRE_O, // done
	input wire logic SYS_TICK_O // tick
);
	logic [3:0] rot;
	logic plain;
	logic jump;
	logic pcl_jump;
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!NRST_I);
	// expected next phase and plain fetch
	assign rot = {PHASE_O[2:0], PHASE_O[3]};
	assign plain = EXEC_VALID_O && !(BRANCH_I || PCL_WR_I || SKIP_I || EXTENDED_I);
	// fetch edges that end a jump or a pc low write
	assign jump = FETCH_O && EXEC_VALID_O && BRANCH_I && !EXTENDED_I;
	assign pcl_jump = FETCH_O && EXEC_VALID_O && PCL_WR_I && !BRANCH_I && !EXTENDED_I;
	////////////////////////////////////////////////////////////////
	// phases one-hot and in order, fetch and retire phases, ir load, pc step and branch dummy
	chk_phase_onehot: assert property ($onehot(PHASE_O))
		else $error("phase not one-hot");
	chk_phase_order: assert property (SYS_TICK_O |=> PHASE_O == $past(rot))
		else $error("phase order broken");
	chk_phase_hold: assert property (!SYS_TICK_O |=> $stable(PHASE_O))
		else $error("phase moved without tick");
	chk_fetch_phase: assert property (FETCH_O |-> PHASE_O == 4'h1 && SYS_TICK_O)
		else $error("fetch outside phase one");
	chk_retire_phase: assert property (RETIRE_O |-> PHASE_O == 4'h8 && EXEC_VALID_O)
		else $error("retire outside phase four");
	chk_ir_load: assert property (FETCH_O && !EXTENDED_I |=> IR_O == $past(INSTR_I))
		else $error("ir missed fetched word");
	chk_pc_step: assert property (FETCH_O && plain
		|=> FETCH_ADDR_O == $past(FETCH_ADDR_O) + 1'b1)
		else $error("pc did not increment");
	chk_branch_dummy: assert property (jump
		|=> !EXEC_VALID_O && FETCH_ADDR_O == $past(TARGET_I))
		else $error("branch without dummy cycle");
	// pc low write stays in page
	chk_page_jump: assert property (pcl_jump
		|=> !EXEC_VALID_O
		&& FETCH_ADDR_O[PC_W-1:ICP_PAGE_LSB] == $past(FETCH_ADDR_O[PC_W-1:ICP_PAGE_LSB]))
		else $error("pc low write left page or had no dummy");
endmodule : icp_core_checker

bind icp_core icp_core_checker #(.PC_W(PC_W), .IW(IW)) u_icp_core_checker (.CLK_I, .NRST_I,
	.INSTR_I, .EXTENDED_I, .BRANCH_I, .TARGET_I, .SKIP_I, .PCL_WR_I, .PHASE_O, .FETCH_ADDR_O,
	.FETCH_O, .IR_O, .EXEC_VALID_O, .RETIRE_O, .SYS_TICK_O);

// ### tb/icp_prog_mem.sv
// program memory and decoder model for the pipeline core
`timescale 1ns/10ps
module icp_prog_mem
	import icp_pkg::*;
(
	input wire logic [ICP_PC_W-1:0] addr_i, // fetch address
	input wire logic [ICP_IW-1:0] ir_i, // executing word
	output logic [ICP_IW-1:0] instr_o, // word at addr_i
	output logic br_o, // changes pc
	output logic ext_o, // extended
	output logic skip_o, // skip
	output logic pcl_o, // pc low write
	output logic [3:0] op_o, // alu op
	output logic [ICP_DW-1:0] opd_o, // operand
	output logic [ICP_PC_W-1:0] tgt_o // target
);
	logic [ICP_IW-1:0] mem [0:255];
	// only 256 words, so addresses alias
	assign instr_o = mem[addr_i[7:0]];
	// fields: branch, ext, skip, pc low, op, operand
	assign {br_o, ext_o, skip_o, pcl_o, op_o, opd_o} = ir_i;
	assign tgt_o = {6'h00, ir_i[7:0]};
endmodule : icp_prog_mem

// ### tb/tb_top.sv
// self-checking bench for the pipeline core
`timescale 1ns/10ps
module tb_top;
	import icp_pkg::*;
	logic CLK_I = 0, NRST_I = 0, osc_a = 0, osc_b = 0, osc_c = 0, acc_wr = 1, ext, br, skp, pc_low_byte;
	logic [1:0] sel = 2'h0;
	logic [3:0] op;
	logic [7:0] opd;
	logic [13:0] tgt;
	logic [15:0] instr, ir;
	int n_errors = 0, checks_done = 0, cyc = 0;
	////////////////////////////////////////////////////////////////
	// clocks; oscillator pins run free
	always #12.5 CLK_I = ~CLK_I;
	always #1000 osc_a = ~osc_a;
	always #125 osc_b = ~osc_b;
	always #2500 osc_c = ~osc_c;
	icp_core u_icp_core (.CLK_I(CLK_I), .NRST_I(NRST_I), .SLOW_RC_CLK_I(osc_a),
		.FAST_XT_CLK_I(osc_b), .SLOW_XT_CLK_I(osc_c), .CLK_SEL_I(sel), .INSTR_I(instr),
		.EXTENDED_I(ext), .BRANCH_I(br), .TARGET_I(tgt), .SKIP_I(skp), .PCL_WR_I(pc_low_byte),
		.ALU_OP_I(op), .OPERAND_I(opd), .ACC_WR_I(acc_wr), .PHASE_O(), .FETCH_ADDR_O(),
		.FETCH_O(), .IR_O(ir), .EXEC_VALID_O(), .RETIRE_O(), .ACC_O(), .RESULT_O(),
		.CARRY_O(), .SYS_TICK_O());
	icp_prog_mem u_icp_prog_mem (.addr_i(u_icp_core.FETCH_ADDR_O), .ir_i(ir), .instr_o(instr),
		.br_o(br), .ext_o(ext), .skip_o(skp), .pcl_o(pc_low_byte), .op_o(op), .opd_o(opd), .tgt_o(tgt));
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// next fetch strobe, bounded wait
	task automatic fetch(output logic [13:0] a);
		int i;
		i = 0;
		@(negedge CLK_I);
		while (u_icp_core.FETCH_O !== 1'b1 && i < 50)
		begin
			@(negedge CLK_I);
			i++;
		end
		a = u_icp_core.FETCH_ADDR_O;
	endtask : fetch
	// branch, pc low jump and met skip, then accumulator
	task automatic run_program();
		logic [13:0] a;
		logic [13:0] exp [8] = '{14'h0, 14'h1, 14'h2, 14'h10, 14'h11, 14'h40, 14'h41, 14'h42};
		foreach (exp[i])
		begin
			fetch(a);
			chk({2'h0, a}, {2'h0, exp[i]});
		end
		repeat (3) fetch(a);
		// a kept ff word, a doubled xor or a lost carry each change these sums
		chk({8'h0, u_icp_core.ACC_O}, 16'h0017);
		chk({8'h0, u_icp_core.RESULT_O}, 16'h0017);
		chk({15'h0, u_icp_core.CARRY_O}, 16'h0001);
	endtask : run_program
	// tick rate for each source over 400 cycles
	task automatic clock_sources();
		int n;
		int exp [4] = '{400, 5, 40, 2};
		for (int s = 0; s < 4; s++)
		begin
			@(posedge CLK_I) sel <= s[1:0];
			repeat (20) @(posedge CLK_I);
			n = 0;
			repeat (400) @(negedge CLK_I) n += int'(u_icp_core.SYS_TICK_O === 1'b1);
			chk(16'(n inside {[exp[s]-1:exp[s]+1]} ? exp[s] : n), 16'(exp[s]));
		end
	endtask : clock_sources
	task automatic results();
		$display("checks=%0d errors=%0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : results
	////////////////////////////////////////////////////////////////
	// hang guard
	always @(posedge CLK_I)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_errors++;
			results();
		end
	end
	initial
	begin
		// filler is or with zero, leaving the accumulator alone
		foreach (u_icp_prog_mem.mem[i]) u_icp_prog_mem.mem[i] = 16'h0300;
		u_icp_prog_mem.mem[1] = 16'h8010;
		u_icp_prog_mem.mem[2] = 16'h0b99;
		u_icp_prog_mem.mem[16] = 16'h1b40;
		u_icp_prog_mem.mem[64] = 16'h2b00;
		u_icp_prog_mem.mem[65] = 16'h0bff;
		u_icp_prog_mem.mem[66] = 16'h4477;
		u_icp_prog_mem.mem[67] = 16'h00a0;
		repeat (6) @(negedge CLK_I);
		chk({12'h0, u_icp_core.PHASE_O}, 16'h0001);
		chk({2'h0, u_icp_core.FETCH_ADDR_O}, 16'h0000);
		chk({15'h0, u_icp_core.EXEC_VALID_O}, 16'h0000);
		@(posedge CLK_I) NRST_I <= 1'b1;
		run_program();
		clock_sources();
		results();
	end
endmodule : tb_top
